// ==== hdl/lps_bank_ctrl.sv ====
`timescale 1ns/1ns
module lps_bank_ctrl
#(
  parameter int CL = lps_pkg::CAS_LAT,
  parameter int TWR = lps_pkg::TWR_CLK,
  parameter int MEM_WORDS = 16
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire lps_pkg::lps_pins_s pins,
  input wire logic [2:0] burst_cfg,
  output logic [15:0] dq_out,
  output logic dq_oe,
  output logic [3:0] bank_open,
  output logic suspended,
  output logic self_refresh,
  output logic refresh_pulse,
  output logic wd_valid,
  input wire logic wd_ready,
  output lps_pkg::lps_wd_s wd_data
);
  import lps_pkg::*;

  localparam int MA = $clog2(MEM_WORDS);

  // ----------------------------------------------------------
  // pin sampling and link clock edge
  // ----------------------------------------------------------
  logic [$bits(lps_pins_s)-1:0] sp_raw;
  lps_pins_s sp;
  logic clk_prev;
  logic tick;

  lps_sync #(.WIDTH($bits(lps_pins_s))) u_sync
  (
    .clk(ref_clk),
    .reset(reset),
    .d(pins),
    .q(sp_raw)
  );

  assign sp = lps_pins_s'(sp_raw);
  assign tick = sp.clk && !clk_prev;

  // all pins share the same two-flop delay, so they stay aligned to the edge
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      clk_prev <= 1'b0;
    else
      clk_prev <= sp.clk;
  end

  // ----------------------------------------------------------
  // command decode
  // ----------------------------------------------------------
  lps_state_e st;
  logic [9:0] burst_left;
  logic [8:0] cur_col;
  logic [1:0] cur_bank;
  logic cur_ap;
  logic full_pg;
  logic [12:0] open_row [4];
  logic wr_pend;
  logic [3:0] wr_cnt;
  logic [1:0] wr_bank;
  logic [3:0] srex_cnt;
  logic fifo_rdy;
  logic [3:0] cmd;
  logic in_burst;
  logic frz;
  logic run;
  logic cmd_ok;
  logic is_act;
  logic is_rd;
  logic is_wr;
  logic is_pre;
  logic is_bst;
  logic is_arf;
  logic is_srf;
  logic new_acc;
  logic full_cfg;
  logic ap_req;
  logic [9:0] bl;
  logic single_ap;
  logic burst_end;
  logic old_ap_done;
  logic rd_ap_close;
  logic wr_ap_start;
  logic [1:0] ap_bank;
  logic rd_word;
  logic wr_word;
  logic [MA-1:0] rd_col;
  logic [MA-1:0] wr_col;
  logic [1:0] acc_bank;
  logic push;
  lps_wd_s wd_in;

  assign cmd = {sp.cs_n, sp.ras_n, sp.cas_n, sp.we_n};
  assign in_burst = (st == ST_READ) || (st == ST_WRITE);
  // a full buffer stalls like a suspend so no written word is lost
  assign frz = tick && ((in_burst && !sp.cke) || !fifo_rdy);
  assign run = tick && !frz;
  assign cmd_ok = run && (st != ST_SELF) && (st != ST_SREX);
  assign is_act = cmd_ok && (cmd == CMD_ACT);
  assign is_rd = cmd_ok && (cmd == CMD_RD);
  assign is_wr = cmd_ok && (cmd == CMD_WR);
  assign is_pre = cmd_ok && (cmd == CMD_PRE);
  assign is_bst = cmd_ok && (cmd == CMD_BST);
  // refresh address is never looked at
  assign is_arf = cmd_ok && (cmd == CMD_REF) && sp.cke && (bank_open == 4'h0);
  assign is_srf = cmd_ok && (cmd == CMD_REF) && !sp.cke && (bank_open == 4'h0);
  assign new_acc = is_rd || is_wr;
  assign full_cfg = (burst_cfg == BL_FULL);
  assign ap_req = sp.addr[AP_BIT] && !full_cfg;
  assign bl = full_cfg ? 10'h000 : (10'h001 << burst_cfg[1:0]);
  assign single_ap = new_acc && ap_req && (bl == 10'h001);
  assign burst_end = run && in_burst && !new_acc && !is_bst && !full_pg && (burst_left == 10'h001);
  // the running burst finishes, is cut, or is interrupted
  assign old_ap_done = run && in_burst && cur_ap && (new_acc || is_bst || burst_end);
  assign rd_ap_close = (old_ap_done && (st == ST_READ)) || (is_rd && single_ap);
  assign wr_ap_start = (old_ap_done && (st == ST_WRITE)) || (is_wr && single_ap);
  assign ap_bank = old_ap_done ? cur_bank : sp.ba;

  // word selection; the interrupting command takes this edge's slot
  assign rd_word = is_rd || (run && (st == ST_READ) && !new_acc && !is_bst);
  assign wr_word = is_wr || (run && (st == ST_WRITE) && !new_acc && !is_bst);
  assign rd_col = is_rd ? sp.addr[MA-1:0] : cur_col[MA-1:0];
  assign wr_col = is_wr ? sp.addr[MA-1:0] : cur_col[MA-1:0];
  assign acc_bank = is_wr ? sp.ba : cur_bank;
  assign push = wr_word && (sp.byte_mask != 2'h3);
  assign wd_in = '{ba: acc_bank, row: open_row[acc_bank], col: is_wr ? sp.addr[8:0] : cur_col,
                   data: sp.dq};

  // ----------------------------------------------------------
  // burst and refresh state machine
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      st <= ST_IDLE;
      burst_left <= 10'h000;
      cur_col <= 9'h000;
      cur_bank <= 2'h0;
      cur_ap <= 1'b0;
      full_pg <= 1'b0;
    end
    else if (run)
    begin
      case (st)
        ST_SELF:
          if (sp.cke)
            st <= ST_SREX;
        ST_SREX:
          if (srex_cnt == 4'h1)
            st <= ST_IDLE;
        default:
          if (is_srf)
            st <= ST_SELF;
          else if (new_acc)
          begin
            st <= (bl == 10'h001) ? ST_IDLE : (is_rd ? ST_READ : ST_WRITE);
            burst_left <= bl - 10'h001;
            cur_col <= sp.addr[8:0] + 9'h001;
            cur_bank <= sp.ba;
            cur_ap <= ap_req;
            full_pg <= full_cfg;
          end
          else if (is_bst || burst_end)
            st <= ST_IDLE;
          else if (in_burst)
          begin
            burst_left <= burst_left - 10'h001;
            cur_col <= cur_col + 9'h001;
          end
      endcase
    end
  end

  // exit wait, counted in link clocks
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      srex_cnt <= 4'h0;
    else if (run && (st == ST_SELF) && sp.cke)
      srex_cnt <= SREX_CLK;
    else if (run && (st == ST_SREX))
      srex_cnt <= srex_cnt - 4'h1;
  end

  // ----------------------------------------------------------
  // bank tracking and precharge
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      bank_open <= 4'h0;
      for (int i = 0; i < 4; i++)
        open_row[i] <= 13'h0000;
    end
    else if (run)
    begin
      if (rd_ap_close)
        bank_open[ap_bank] <= 1'b0;
      if (wr_pend && (wr_cnt == 4'h1))
        bank_open[wr_bank] <= 1'b0;
      if (is_pre)
      begin
        if (sp.addr[AP_BIT])
          bank_open <= 4'h0;
        else
          bank_open[sp.ba] <= 1'b0;
      end
      if (is_act)
      begin
        bank_open[sp.ba] <= 1'b1;
        open_row[sp.ba] <= sp.addr;
      end
    end
  end

  // write recovery before the automatic close
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      wr_pend <= 1'b0;
      wr_cnt <= 4'h0;
      wr_bank <= 2'h0;
    end
    else if (run)
    begin
      if (wr_ap_start)
      begin
        wr_pend <= 1'b1;
        wr_cnt <= 4'(TWR);
        wr_bank <= ap_bank;
      end
      else if (wr_pend)
      begin
        wr_pend <= (wr_cnt != 4'h1);
        wr_cnt <= wr_cnt - 4'h1;
      end
    end
  end

  // ----------------------------------------------------------
  // data storage and read pipeline
  // ----------------------------------------------------------
  logic [15:0] mem [MEM_WORDS];
  logic [CL-1:0] rp_v;
  logic [15:0] rp_d [CL];
  logic [1:0] dm_d;

  // small store only; columns alias above MEM_WORDS
  always_ff @(posedge ref_clk)
  begin
    if (wr_word && !sp.byte_mask[0])
      mem[wr_col][7:0] <= sp.dq[7:0];
    if (wr_word && !sp.byte_mask[1])
      mem[wr_col][15:8] <= sp.dq[15:8];
  end

  // pipeline halts while frozen, so output data holds
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      rp_v <= '0;
      for (int i = 0; i < CL; i++)
        rp_d[i] <= 16'h0000;
    end
    else if (run)
    begin
      rp_v <= {rp_v[CL-2:0], rd_word};
      rp_d[0] <= mem[rd_col];
      for (int i = 1; i < CL; i++)
        rp_d[i] <= rp_d[i-1];
    end
  end

  // byte masks gate the read drivers two clocks later
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      dm_d <= 2'h0;
    else if (tick)
      dm_d <= {dm_d[0], |sp.byte_mask};
  end

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      dq_out <= 16'h0000;
      dq_oe <= 1'b0;
      suspended <= 1'b0;
      self_refresh <= 1'b0;
      refresh_pulse <= 1'b0;
    end
    else
    begin
      if (run)
      begin
        dq_out <= rp_d[CL-1];
        dq_oe <= rp_v[CL-1] && !dm_d[1];
      end
      suspended <= in_burst && !sp.cke;
      self_refresh <= (st == ST_SELF);
      refresh_pulse <= is_arf;
    end
  end

  lps_fifo2 #(.W($bits(lps_wd_s)), .DEPTH(2)) u_buf
  (
    .clk(ref_clk),
    .reset(reset),
    .in_valid(push),
    .in_ready(fifo_rdy),
    .in_data(wd_in),
    .out_valid(wd_valid),
    .out_ready(wd_ready),
    .out_data(wd_data)
  );

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  property p_freeze;
    frz |=> $stable(burst_left) && $stable(cur_col) && $stable(st);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  property p_ignore;
    frz && in_burst |=> $stable(bank_open) && !refresh_pulse;
  endproperty
  a_ignore: assert property (p_ignore) else $error("command taken while frozen");

  property p_hold;
    frz |=> $stable(dq_out) && $stable(dq_oe);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved while frozen");

  property p_resume;
    run && in_burst && !full_pg && !new_acc && !is_bst && (burst_left > 10'h001)
      |=> burst_left == $past(burst_left) - 10'h001;
  endproperty
  a_resume: assert property (p_resume) else $error("burst did not advance");

  property p_pre_all;
    is_pre && sp.addr[AP_BIT] |=> bank_open == 4'h0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");

  property p_full_noap;
    in_burst && full_pg |-> !cur_ap;
  endproperty
  a_full_noap: assert property (p_full_noap) else $error("auto close in full page");

  property p_noap;
    new_acc && !sp.addr[AP_BIT] |=> !cur_ap;
  endproperty
  a_noap: assert property (p_noap) else $error("auto close carried over");

  property p_rd_intr;
    (st == ST_READ) && cur_ap && new_acc && (sp.ba != cur_bank) |=> !bank_open[$past(cur_bank)];
  endproperty
  a_rd_intr: assert property (p_rd_intr) else $error("interrupted read bank still open");

  property p_wr_intr;
    (st == ST_WRITE) && cur_ap && new_acc |=> wr_pend && (wr_bank == $past(cur_bank));
  endproperty
  a_wr_intr: assert property (p_wr_intr) else $error("write recovery not started");

  property p_sref;
    (st == ST_SELF) && !sp.cke |=> (st == ST_SELF) && $stable(bank_open);
  endproperty
  a_sref: assert property (p_sref) else $error("left self refresh with enable low");

  property p_ref;
    is_arf |=> refresh_pulse ##1 !refresh_pulse;
  endproperty
  a_ref: assert property (p_ref) else $error("refresh pulse not one cycle");

  c_susp: cover property (frz && in_burst && !sp.cke);
  c_rd_intr: cover property ((st == ST_READ) && cur_ap && new_acc);
  c_wr_rec: cover property (wr_pend && (wr_cnt == 4'h1) && run);
  c_sref: cover property ((st == ST_SREX) ##[1:40] (st == ST_IDLE));

endmodule : lps_bank_ctrl

// ==== hdl/lps_pkg.sv ====
package lps_pkg;

  // ----------------------------------------------------------
  // timing, in link clocks
  // ----------------------------------------------------------
  localparam int CAS_LAT = 2;
  localparam int TWR_CLK = 1;
  localparam logic [3:0] SREX_CLK = 4'h2;

  // ----------------------------------------------------------
  // field positions and encodings
  // ----------------------------------------------------------
  localparam int AP_BIT = 11;
  localparam logic [2:0] BL_FULL = 3'h7;
  // {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_BST = 4'h6;

  // ----------------------------------------------------------
  // types
  // ----------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_WRITE, ST_SELF, ST_SREX} lps_state_e;

  typedef struct packed {
    logic clk;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [12:0] addr;
    logic [1:0] byte_mask;
    logic [15:0] dq;
  } lps_pins_s;

  typedef struct packed {
    logic [1:0] ba;
    logic [12:0] row;
    logic [8:0] col;
    logic [15:0] data;
  } lps_wd_s;

endpackage : lps_pkg

// ==== hdl/lps_sync.sv ====
`timescale 1ns/1ns
// two-stage synchroniser; first stage feeds only the second
module lps_sync
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : lps_sync

// ==== hdl/lps_fifo2.sv ====
`timescale 1ns/1ns
// shift-style buffer; head slot is a flop so the outputs are registered
module lps_fifo2
#(
  parameter int W = 8,
  parameter int DEPTH = 2
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [DEPTH-1:0] v;
  logic [DEPTH-1:0] next_v;
  logic [W-1:0] d [DEPTH];
  logic [W-1:0] next_d [DEPTH];
  logic pop;
  logic push;
  logic done;

  assign in_ready = !v[DEPTH-1];
  assign out_valid = v[0];
  assign out_data = d[0];
  assign pop = v[0] && out_ready;
  assign push = in_valid && in_ready;

  // pop shifts toward the head, push fills the first free slot
  always_comb
  begin
    done = 1'b0;
    next_v = v;
    next_d = d;
    if (pop)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        next_v[i] = v[i+1];
        next_d[i] = d[i+1];
      end
      next_v[DEPTH-1] = 1'b0;
    end
    for (int i = 0; i < DEPTH; i++)
    begin
      if (push && !done && !next_v[i])
      begin
        next_v[i] = 1'b1;
        next_d[i] = in_data;
        done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      v <= '0;
    else
      v <= next_v;
  end

  // data needs no reset; valid bits guard it
  always_ff @(posedge clk)
  begin
    d <= next_d;
  end

endmodule : lps_fifo2

// ==== tb/lps_ctrl_model.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------
// memory controller stand-in driving the link pins
// ----------------------------------------------------------
module lps_ctrl_model
(
  input wire logic ref_clk,
  output lps_pkg::lps_pins_s pins
);
  import lps_pkg::*;

  // deselected and idle, link clock parked low
  initial
  begin
    pins = '0;
    pins.cke = 1'b1;
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = 4'hF;
  end

  // one command per link clock; 800 ns covers every recovery wait
  task issue(input logic [3:0] c, input logic k, input logic [1:0] b, input logic [12:0] a,
             input logic [1:0] m, input logic [15:0] d, input logic dr);
    @(negedge ref_clk);
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = c;
    pins.cke = k;
    pins.ba = b;
    pins.addr = a;
    pins.byte_mask = m;
    // a released bus must not keep showing the last word
    pins.dq = dr ? d : ~pins.dq;
    repeat (3) @(negedge ref_clk);
    pins.clk = 1'b1;
    repeat (4) @(negedge ref_clk);
    // clock stands still between commands, lines no longer hold
    pins.clk = 1'b0;
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = 4'hF;
    pins.addr = ~pins.addr;
  endtask : issue
endmodule : lps_ctrl_model

// ==== tb/test_lps_bank_ctrl.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; $display("BAD %0t: got %h expected %h", $time, (a), (b)); end end
module test_lps_bank_ctrl;
  import lps_pkg::*;

  // ----------------------------------------------------------
  // signals and bookkeeping
  // ----------------------------------------------------------
  localparam logic [3:0] cmd_nop = 4'h7;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] burst_cfg = 3'h2;
  logic wd_ready = 1'b1;
  logic hold_rdy = 1'b0;
  logic [7:0] lf = 8'h24;
  lps_pins_s pins;
  logic [15:0] dq_out;
  logic dq_oe;
  logic [3:0] bank_open;
  logic suspended;
  logic self_refresh;
  logic refresh_pulse;
  logic wd_valid;
  lps_wd_s wd_data;
  int fails = 0;
  int compares = 0;
  int refs = 0;
  logic [12:0] row [4];
  logic [15:0] wdat [4];
  logic [15:0] v;
  logic [15:0] rd_q [$];
  lps_wd_s wd_q [$];
  lps_wd_s exp_q [$];

  lps_ctrl_model u_ctl (.ref_clk(ref_clk), .pins(pins));

  lps_bank_ctrl #(.MEM_WORDS(16)) DUT (
    .ref_clk(ref_clk), .reset(reset), .pins(pins), .burst_cfg(burst_cfg),
    .dq_out(dq_out), .dq_oe(dq_oe), .bank_open(bank_open), .suspended(suspended),
    .self_refresh(self_refresh), .refresh_pulse(refresh_pulse),
    .wd_valid(wd_valid), .wd_ready(wd_ready), .wd_data(wd_data)
  );

  always #50 ref_clk = ~ref_clk;

  // ----------------------------------------------------------
  // random source and monitors
  // ----------------------------------------------------------
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nxt

  // receiver stalls about a quarter of the time
  always @(negedge ref_clk)
  begin
    lf <= nxt(lf);
    wd_ready <= !hold_rdy && (lf[1:0] != 2'h0);
  end

  always @(posedge ref_clk)
  begin
    if (wd_valid === 1'b1 && wd_ready) wd_q.push_back(wd_data);
    if (refresh_pulse === 1'b1) refs++;
  end

  // read word is settled well after the tick; suspended ticks are skipped
  always @(posedge pins.clk)
  begin
    repeat (6) @(posedge ref_clk);
    if (dq_oe === 1'b1 && suspended !== 1'b1) rd_q.push_back(dq_out);
  end

  // ----------------------------------------------------------
  // command helpers
  // ----------------------------------------------------------
  // back-to-back calls give an 800 ns link clock
  task cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a, input logic k = 1'b1,
           input logic [15:0] d = 16'h0, input logic dr = 1'b0, input logic [1:0] m = 2'h0);
    u_ctl.issue(c, k, b, a, m, d, dr);
  endtask : cmd

  task nops(input int n);
    repeat (n) cmd(cmd_nop, 2'h0, 13'h0);
  endtask : nops

  task act(input logic [1:0] b);
    row[b] = {lf[4:0], lf};
    cmd(CMD_ACT, b, row[b]);
  endtask : act

  task wr(input logic [1:0] b, input logic [8:0] col, input int n, input logic ap);
    for (int i = 0; i < n; i++)
    begin
      wdat[i] = {lf, lf ^ 8'hA5};
      exp_q.push_back('{b, row[b], 9'(col + i), wdat[i]});
      if (i == 0) cmd(CMD_WR, b, {1'b0, ap, 2'h0, col}, 1'b1, wdat[i], 1'b1);
      else cmd(cmd_nop, b, 13'h0, 1'b1, wdat[i], 1'b1);
    end
  endtask : wr

  task rd(input logic [1:0] b, input logic ap);
    rd_q.delete();
    cmd(CMD_RD, b, {1'b0, ap, 11'h0});
  endtask : rd

  task chk_rd(input int n);
    `CHK(rd_q.size(), n)
    for (int i = 0; i < n && i < rd_q.size(); i++) `CHK(rd_q[i], wdat[i])
  endtask : chk_rd

  task chk_wd();
    `CHK(wd_q.size(), exp_q.size())
    for (int i = 0; i < exp_q.size() && i < wd_q.size(); i++) `CHK(wd_q[i], exp_q[i])
    wd_q.delete();
    exp_q.delete();
  endtask : chk_wd

  task finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------
  // watchdog, far beyond the expected 72 us of traffic
  // ----------------------------------------------------------
  initial
  begin
    #3000000;
    fails++;
    finish_test();
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial
  begin
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    repeat (4) @(negedge ref_clk);
    `CHK({bank_open, dq_oe, self_refresh, wd_valid}, 7'h00)
    act(2'h0);
    `CHK(bank_open, 4'h1)
    act(2'h1);
    `CHK(bank_open, 4'h3)
    // write burst without close, then read back with close
    wr(2'h0, 9'h0, 4, 1'b0);
    nops(2);
    `CHK(bank_open, 4'h3)
    chk_wd();
    rd(2'h0, 1'b1);
    nops(6);
    chk_rd(4);
    `CHK(bank_open, 4'h2)
    // auto close interrupted by a read to another bank
    act(2'h0);
    rd(2'h0, 1'b1);
    nops(1);
    cmd(CMD_RD, 2'h1, 13'h0);
    `CHK(bank_open[0], 1'b0)
    nops(6);
    `CHK(bank_open, 4'h2)
    `CHK(rd_q.size(), 6)
    // full page keeps the row, terminate ends the burst
    burst_cfg = 3'h7;
    act(2'h0);
    rd(2'h0, 1'b1);
    nops(4);
    cmd(CMD_BST, 2'h0, 13'h0);
    nops(4);
    `CHK(dq_oe, 1'b0)
    `CHK(bank_open, 4'h3)
    burst_cfg = 3'h2;
    // suspend in mid read burst
    rd(2'h0, 1'b0);
    nops(1);
    cmd(cmd_nop, 2'h0, 13'h0, 1'b0);
    `CHK(suspended, 1'b1)
    v = dq_out;
    cmd(CMD_ACT, 2'h2, 13'h0, 1'b0);
    `CHK(dq_out, v)
    `CHK(bank_open, 4'h3)
    cmd(cmd_nop, 2'h0, 13'h0);
    nops(5);
    `CHK(suspended, 1'b0)
    chk_rd(4);
    // single bank and all bank close
    cmd(CMD_PRE, 2'h1, 13'h0);
    `CHK(bank_open, 4'h1)
    act(2'h2);
    act(2'h3);
    `CHK(bank_open, 4'hD)
    cmd(CMD_PRE, 2'h0, 13'h0800);
    `CHK(bank_open, 4'h0)
    // refresh with random address, refused while a bank is open
    repeat (3) cmd(CMD_REF, lf[1:0], {lf[4:0], lf});
    nops(1);
    `CHK(refs, 3)
    act(2'h0);
    cmd(CMD_REF, 2'h0, 13'h0);
    nops(1);
    `CHK(refs, 3)
    cmd(CMD_PRE, 2'h0, 13'h0);
    // self refresh entry, ignored command, exit with two idle clocks
    cmd(CMD_REF, 2'h0, 13'h0, 1'b0);
    `CHK(self_refresh, 1'b1)
    cmd(CMD_ACT, 2'h1, 13'h0, 1'b0);
    `CHK(bank_open, 4'h0)
    cmd(cmd_nop, 2'h0, 13'h0);
    nops(2);
    `CHK(self_refresh, 1'b0)
    act(2'h0);
    `CHK(bank_open, 4'h1)
    // receiver stalls while a closing write fills the buffer
    burst_cfg = 3'h1;
    hold_rdy = 1'b1;
    wr(2'h0, 9'h4, 2, 1'b1);
    nops(1);
    `CHK(wd_valid, 1'b1)
    `CHK(wd_q.size(), 0)
    hold_rdy = 1'b0;
    nops(3);
    chk_wd();
    `CHK(bank_open, 4'h0)
    // closing read cut by a write, closing writes cut by a write and then a read
    burst_cfg = 3'h2;
    act(2'h0);
    act(2'h1);
    act(2'h2);
    act(2'h3);
    rd_q.delete();
    cmd(CMD_RD, 2'h0, 13'h0800, 1'b1, 16'h0, 1'b0, 2'h3);
    cmd(cmd_nop, 2'h0, 13'h0, 1'b1, 16'h0, 1'b0, 2'h3);
    wr(2'h1, 9'h8, 2, 1'b1);
    `CHK(bank_open[0], 1'b0)
    wr(2'h2, 9'hC, 2, 1'b1);
    cmd(CMD_RD, 2'h3, 13'h0);
    nops(6);
    `CHK(rd_q.size(), 4)
    `CHK(bank_open, 4'h8)
    `CHK(wd_q.size(), 4)
    chk_wd();
    finish_test();
  end
endmodule : test_lps_bank_ctrl
